/* File: rtl/pll_band_select_config.sv */
/*
 * PLL configuration register, band search controller and lock reporting.
 * Assumes the serial port logic presents decoded register accesses, and
 * the analog PLL returns a lock level asynchronous to the system clock.
 */
`timescale 1ns/1ps
module pll_band_select_config #(
	parameter int SETTLE_CYCLES = pll_band_pkg::SETTLE_CYC_I
) (
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_ARST_N,
	input  wire logic        i_REG_WR,
	input  wire logic        i_REG_RD,
	input  wire logic [4:0]  i_REG_ADDR,
	input  wire logic [31:0] i_REG_WDATA,
	input  wire logic        i_PLL_LOOP_LOCKED,
	input  wire logic        i_REF_CLK_PRESENT,
	output logic      [31:0] o_REG_RDATA,
	output logic      [5:0]  o_VCO_BAND,
	output logic             o_PLL_LOCK,
	output logic             o_MULT_SELECT,
	output logic      [1:0]  o_VCO_LOOP_DIVIDER,
	output logic      [1:0]  o_SAMPLE_CLOCK_MULTIPLIER,
	output logic      [4:0]  o_LOOP_BANDWIDTH,
	output logic      [1:0]  o_VCO_DRIVE,
	output logic      [2:0]  o_PLL_BIAS,
	output logic             o_SEARCHING
);
	pll_band_pkg::state_t   s_q;
	pll_band_pkg::state_t   s_d;
	pll_band_pkg::reg_req_t req;
	logic [1:0]             pins_sync;
	logic                   loop_locked;
	logic                   ref_present;
	logic                   ctrl_wr;
	logic [5:0]             wr_band;
	logic [pll_band_pkg::CNT_W-1:0] settle_cyc;

	assign req.wr    = i_REG_WR;
	assign req.rd    = i_REG_RD;
	assign req.addr  = i_REG_ADDR;
	assign req.wdata = i_REG_WDATA;
	assign settle_cyc = SETTLE_CYCLES[pll_band_pkg::CNT_W-1:0];

	// Lock and reference detect come from the analog side.
	pin_sync2 #(
		.WIDTH (2)
	) u_sync (
		.i_clk    (I_CLK_SYS),
		.i_arst_n (I_ARST_N),
		.i_async  ({i_REF_CLK_PRESENT, i_PLL_LOOP_LOCKED}),
		.o_sync   (pins_sync)
	);
	assign loop_locked = pins_sync[0];
	assign ref_present = pins_sync[1];

	assign ctrl_wr = req.wr && (req.addr == pll_band_pkg::ADDR_PLL_CTRL);
	assign wr_band = req.wdata[pll_band_pkg::BAND_MSB:pll_band_pkg::BAND_LSB];

	always_comb begin
		s_d = s_q;

		unique case (s_q.mode)
			pll_band_pkg::MODE_SEARCH: begin
				// Each band gets a settle window before the lock is judged.
				if (!ref_present) begin // R08
					s_d.cnt = pll_band_pkg::CNT_ZERO;
				end else if (s_q.cnt < settle_cyc) begin
					s_d.cnt = s_q.cnt + pll_band_pkg::CNT_ONE;
				end else if (loop_locked) begin // R02
					s_d.mode = pll_band_pkg::MODE_FOUND;
					// The found band replaces the auto code in the field.
					s_d.ctrl[pll_band_pkg::BAND_MSB:pll_band_pkg::BAND_LSB] =
						s_q.band; // R04
				end else begin
					s_d.cnt = pll_band_pkg::CNT_ZERO;
					// Bands are tried from lowest to highest, then wrap.
					if (s_q.band == pll_band_pkg::BAND_TOP) begin // R09
						s_d.band = pll_band_pkg::BAND_FIRST;
					end else begin
						s_d.band = s_q.band + 6'h01;
					end
				end
			end
			pll_band_pkg::MODE_FOUND: begin
				s_d.band = s_q.band;
			end
			pll_band_pkg::MODE_MANUAL: begin
				s_d.band = s_q.ctrl[pll_band_pkg::BAND_MSB:pll_band_pkg::BAND_LSB];
			end
			default: begin
				s_d.mode = pll_band_pkg::MODE_MANUAL;
			end
		endcase

		// A software write to the control register overrides the search.
		if (ctrl_wr) begin
			s_d.ctrl = req.wdata[pll_band_pkg::CTRL_W-1:0];
			s_d.cnt  = pll_band_pkg::CNT_ZERO;
			if (wr_band == pll_band_pkg::BAND_AUTO) begin // R01
				s_d.mode = pll_band_pkg::MODE_SEARCH;
				s_d.band = pll_band_pkg::BAND_FIRST;
			end else begin
				s_d.mode = pll_band_pkg::MODE_MANUAL; // R05
				s_d.band = wr_band; // R05
			end
		end

		// Lock is only reported once no search is running.
		if (s_d.mode == pll_band_pkg::MODE_SEARCH) begin
			s_d.lock      = 1'b0; // R12
			s_d.searching = 1'b1; // R12
		end else begin
			s_d.lock      = loop_locked; // R03
			s_d.searching = 1'b0;
		end

		if (req.rd) begin
			if (req.addr == pll_band_pkg::ADDR_PLL_CTRL) begin
				s_d.rdata = {{(pll_band_pkg::DATA_W - pll_band_pkg::CTRL_W){1'b0}},
					s_q.ctrl}; // R04
			end else if (req.addr == pll_band_pkg::ADDR_STATUS) begin
				s_d.rdata = 32'h00000000;
				s_d.rdata[pll_band_pkg::STAT_LOCK_BIT] = s_q.lock; // R03
			end else begin
				s_d.rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			s_q.ctrl  <= pll_band_pkg::CTRL_RESET;
			s_q.mode  <= pll_band_pkg::MODE_MANUAL;
			s_q.band  <= pll_band_pkg::BAND_FIRST;
			s_q.cnt   <= pll_band_pkg::CNT_ZERO;
			s_q.lock  <= 1'b0;
			s_q.searching <= 1'b0;
			s_q.rdata <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end

	// Analog controls other than the VCO band are taken straight from the held register fields.
	assign o_REG_RDATA  = s_q.rdata;
	assign o_VCO_BAND   = s_q.band; // R09
	assign o_PLL_LOCK   = s_q.lock; // R03
	assign o_MULT_SELECT = s_q.ctrl[pll_band_pkg::PLL_EN_BIT]; // R10
	assign o_VCO_LOOP_DIVIDER =
		s_q.ctrl[pll_band_pkg::LDIV_MSB:pll_band_pkg::LDIV_LSB]; // R11
	assign o_SAMPLE_CLOCK_MULTIPLIER =
		s_q.ctrl[pll_band_pkg::SMULT_MSB:pll_band_pkg::SMULT_LSB]; // R11
	assign o_LOOP_BANDWIDTH = s_q.ctrl[pll_band_pkg::BW_MSB:pll_band_pkg::BW_LSB];
	assign o_VCO_DRIVE  = s_q.ctrl[pll_band_pkg::DRIVE_MSB:pll_band_pkg::DRIVE_LSB];
	assign o_PLL_BIAS   = s_q.ctrl[pll_band_pkg::BIAS_MSB:pll_band_pkg::BIAS_LSB];
	assign o_SEARCHING  = s_q.searching; // R12
endmodule

/* File: common/pll_band_pkg.sv */
/*
 * Constants, field layout and state types for the PLL band select block.
 * Assumes one 40 MHz system clock and register numbers as the port address.
 */
// What this block, its software and the analog side do
// R01: Band field is bits 7:2 of the control register; writing 63 starts auto.
// R02: In auto mode the block steps through bands to find one that locks.
// R03: On lock, the pin goes high and status bit 3 is set, within 5 ms.
// R04: After the search, reading the band field returns the band found.
// R05: Software rewrites the band with a temperature offset; block then uses it.
// R06: Software programs both divider fields before starting the search.
// R07: Software sets bandwidth 01111, drive 11 and bias 011.
// R08: The reference clock keeps running throughout the band search.
// R09: Codes 0 to 62 choose a VCO band, low to high; 63 is auto.
// R10: Bit 15 picks the multiplier, else the reference clock drives the DAC.
// R11: VCO runs at ref times both dividers; sample clock at ref times second.
// R12: While the search runs, the lock bit and lock pin stay low.
package pll_band_pkg;

	localparam int          ADDR_W         = 5;
	localparam int          DATA_W         = 32;
	localparam int          CTRL_W         = 21;
	localparam logic [4:0]  ADDR_PLL_CTRL  = 5'h04;
	localparam logic [4:0]  ADDR_STATUS    = 5'h09;

	localparam int          BAND_LSB       = 2;
	localparam int          BAND_MSB       = 7;
	localparam int          DRIVE_LSB      = 0;
	localparam int          DRIVE_MSB      = 1;
	localparam int          BIAS_LSB       = 8;
	localparam int          BIAS_MSB       = 10;
	localparam int          SMULT_LSB      = 11;
	localparam int          SMULT_MSB      = 12;
	localparam int          LDIV_LSB       = 13;
	localparam int          LDIV_MSB       = 14;
	localparam int          PLL_EN_BIT     = 15;
	localparam int          BW_LSB         = 16;
	localparam int          BW_MSB         = 20;
	localparam int          STAT_LOCK_BIT  = 3;

	localparam logic [5:0]  BAND_AUTO      = 6'h3F;
	localparam logic [5:0]  BAND_TOP       = 6'h3E;
	localparam logic [5:0]  BAND_FIRST     = 6'h00;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 21'h000000;

	localparam int          CLK_HZ         = 40000000;
	localparam int          LOCK_WAIT_MS   = 5;
	localparam int          BAND_SETTLE_US = 50;
	localparam int          SETTLE_CYC_I   =
		(CLK_HZ / 1000000) * BAND_SETTLE_US;
	localparam int          CNT_W          = 16;
	localparam logic [CNT_W-1:0] SETTLE_CYC = SETTLE_CYC_I[CNT_W-1:0];
	localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;

	typedef enum logic [1:0] {
		MODE_MANUAL = 2'b00,
		MODE_SEARCH = 2'b01,
		MODE_FOUND  = 2'b10
	} mode_t;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		mode_t             mode;
		logic [5:0]        band;
		logic [CNT_W-1:0]  cnt;
		logic              lock;
		logic              searching;
		logic [DATA_W-1:0] rdata;
	} state_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

endpackage

/* File: rtl/pin_sync2.sv */
/*
 * Two-flop synchroniser, one lane per bit.
 * Assumes inputs are levels from outside the system clock domain.
 */
`timescale 1ns/1ps
module pin_sync2 #(
	parameter int WIDTH = 2
) (
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_lane
			logic meta_q;
			logic sync_q;
			always_ff @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= i_async[g];
					sync_q <= meta_q;
				end
			end
			assign o_sync[g] = sync_q;
		end
	endgenerate
endmodule

/* File: verification/pll_band_props.sv */
/* Port assertions for the PLL band select block.
   Assumes the block package is compiled first; bound to every instance. */
`timescale 1ns/1ps
module pll_band_props #(
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic	I_CLK_SYS,
	input wire logic	I_ARST_N,
	input wire logic	i_REG_WR,
	input wire logic	i_REG_RD,
	input wire logic [4:0]	i_REG_ADDR,
	input wire logic [31:0]	i_REG_WDATA,
	input wire logic	i_PLL_LOOP_LOCKED,
	input wire logic	i_REF_CLK_PRESENT,
	input wire logic [31:0]	o_REG_RDATA,
	input wire logic [5:0]	o_VCO_BAND,
	input wire logic	o_PLL_LOCK,
	input wire logic	o_MULT_SELECT,
	input wire logic [1:0]	o_VCO_LOOP_DIVIDER,
	input wire logic [1:0]	o_SAMPLE_CLOCK_MULTIPLIER,
	input wire logic [4:0]	o_LOOP_BANDWIDTH,
	input wire logic [1:0]	o_VCO_DRIVE,
	input wire logic [2:0]	o_PLL_BIAS,
	input wire logic	o_SEARCHING
);
	logic [15:0]	wait_q;
	logic [15:0]	wait_d;
	logic		ctrl_wr;
	logic		go;
	assign ctrl_wr = i_REG_WR && i_REG_ADDR == pll_band_pkg::ADDR_PLL_CTRL;
	assign go = i_PLL_LOOP_LOCKED && i_REF_CLK_PRESENT && !i_REG_WR;
	// Counts search cycles spent while a lock is on offer.
	always_comb begin
		wait_d = (o_SEARCHING && go) ? wait_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wait_q <= 16'h0000;
		end else begin
			wait_q <= wait_d;
		end
	end
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);
	sequence s_auto_wr;
		ctrl_wr && i_REG_WDATA[7:2] == 6'h3F;
	endsequence
	sequence s_man_wr;
		ctrl_wr && i_REG_WDATA[7:2] != 6'h3F;
	endsequence
	auto_start_a: assert property (s_auto_wr |=> o_SEARCHING)
		else $error("auto write did not start search");
	man_band_a: assert property (s_man_wr |=> !o_SEARCHING &&
		o_VCO_BAND == $past(i_REG_WDATA[7:2]))
		else $error("manual band not applied");
	clk_fields_a: assert property (ctrl_wr |=>
		{o_MULT_SELECT, o_VCO_LOOP_DIVIDER, o_SAMPLE_CLOCK_MULTIPLIER}
		== $past(i_REG_WDATA[15:11])) else $error("clock fields wrong");
	tune_fields_a: assert property (ctrl_wr |=>
		{o_LOOP_BANDWIDTH, o_PLL_BIAS, o_VCO_DRIVE} == {$past(i_REG_WDATA[20:16]),
		$past(i_REG_WDATA[10:8]), $past(i_REG_WDATA[1:0])})
		else $error("tuning fields wrong");
	lock_low_a: assert property (o_SEARCHING |-> !o_PLL_LOCK)
		else $error("lock high during search");
	band_range_a: assert property (o_SEARCHING |-> o_VCO_BAND != 6'h3F)
		else $error("auto code driven to oscillator");
	search_time_a: assert property (wait_q <= SETTLE_CYCLES + 6)
		else $error("search ran on with lock offered");
	status_rd_a: assert property (i_REG_RD &&
		i_REG_ADDR == pll_band_pkg::ADDR_STATUS
		|=> o_REG_RDATA[3] == $past(o_PLL_LOCK)) else $error("status lock bit");
	band_rd_a: assert property (i_REG_RD && !i_REG_WR && !o_SEARCHING &&
		i_REG_ADDR == pll_band_pkg::ADDR_PLL_CTRL
		|=> o_REG_RDATA[7:2] == $past(o_VCO_BAND)) else $error("band readback");
endmodule
bind pll_band_select_config pll_band_props
	#(.SETTLE_CYCLES(SETTLE_CYCLES)) pll_band_props_i (.*);

/* File: verification/test_pll_band_select_config.sv */
/* Self-checking bench for the PLL band select block.
   Assumes the block package and the bound checker are compiled first. */
`timescale 1ns/1ps
module test_pll_band_select_config;
	logic		I_CLK_SYS = 1'b0;
	logic		I_ARST_N = 1'b0;
	logic		i_REG_WR = 1'b0;
	logic		i_REG_RD = 1'b0;
	logic		i_PLL_LOOP_LOCKED = 1'b0;
	logic		i_REF_CLK_PRESENT = 1'b1;
	logic [4:0]	i_REG_ADDR = 5'h00;
	logic [31:0]	i_REG_WDATA = 32'h00000000;
	logic [31:0]	o_REG_RDATA;
	logic [5:0]	o_VCO_BAND;
	logic		o_PLL_LOCK, o_MULT_SELECT, o_SEARCHING;
	logic [1:0]	o_VCO_LOOP_DIVIDER, o_SAMPLE_CLOCK_MULTIPLIER, o_VCO_DRIVE;
	logic [4:0]	o_LOOP_BANDWIDTH;
	logic [2:0]	o_PLL_BIAS;
	int		num_errors = 0;
	int		comparisons = 0;
	int		cycles = 0;
	always #12.5 I_CLK_SYS = ~I_CLK_SYS;
	pll_band_select_config #(.SETTLE_CYCLES(4)) pll_band_select_config_i (.*);
	task automatic check(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic access(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(negedge I_CLK_SYS);
		i_REG_WR = w;
		i_REG_RD = !w;
		i_REG_ADDR = a;
		i_REG_WDATA = d;
		@(negedge I_CLK_SYS);
		i_REG_WR = 1'b0;
		i_REG_RD = 1'b0;
		@(negedge I_CLK_SYS);
	endtask
	task automatic wait_done();
		for (int i = 0; i < 200 && o_SEARCHING !== 1'b0; i++) begin
			@(negedge I_CLK_SYS);
		end
		check("search done", 32'h0, o_SEARCHING);
	endtask
	task automatic t_fields();
		access(1'b0, 5'h1F, 32'h0);
		check("unmapped read", 32'h0, o_REG_RDATA);
		access(1'b1, pll_band_pkg::ADDR_PLL_CTRL, 32'hFFEFCB17);
		check("band", 32'h05, o_VCO_BAND);
		check("clock fields", 32'h19,
			{o_MULT_SELECT, o_VCO_LOOP_DIVIDER, o_SAMPLE_CLOCK_MULTIPLIER});
		check("tuning", 32'h1EF, {o_LOOP_BANDWIDTH, o_PLL_BIAS, o_VCO_DRIVE});
		access(1'b0, pll_band_pkg::ADDR_PLL_CTRL, 32'h0);
		check("ctrl read", 32'h000FCB17, o_REG_RDATA);
	endtask
	task automatic t_auto();
		i_PLL_LOOP_LOCKED = 1'b1;
		access(1'b1, pll_band_pkg::ADDR_PLL_CTRL, 32'h000FCBFF);
		check("search flags", 32'h2, {o_SEARCHING, o_PLL_LOCK});
		wait_done();
		check("lock pin", 32'h1, o_PLL_LOCK);
		access(1'b0, pll_band_pkg::ADDR_PLL_CTRL, 32'h0);
		check("found band", 32'h000FCB03, o_REG_RDATA);
		access(1'b0, pll_band_pkg::ADDR_STATUS, 32'h0);
		check("status", 32'h8, o_REG_RDATA);
	endtask
	task automatic t_pause();
		i_PLL_LOOP_LOCKED = 1'b0;
		i_REF_CLK_PRESENT = 1'b0;
		access(1'b1, pll_band_pkg::ADDR_PLL_CTRL, 32'h000FCBFF);
		repeat (40) @(negedge I_CLK_SYS);
		check("paused band", 32'h0, o_VCO_BAND);
		access(1'b0, pll_band_pkg::ADDR_STATUS, 32'h0);
		check("status busy", 32'h0, o_REG_RDATA);
		i_REF_CLK_PRESENT = 1'b1;
		i_PLL_LOOP_LOCKED = 1'b1;
		wait_done();
		check("band after pause", 32'h0, o_VCO_BAND);
	endtask
	task automatic t_manual();
		access(1'b1, pll_band_pkg::ADDR_PLL_CTRL, 32'h000F4B0B);
		check("manual band", 32'h02, {o_MULT_SELECT, o_VCO_BAND});
		check("manual lock", 32'h1, o_PLL_LOCK);
	endtask
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge I_CLK_SYS) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (8) @(negedge I_CLK_SYS);
		I_ARST_N = 1'b1;
		t_fields();
		t_auto();
		t_pause();
		t_manual();
		complete_run();
	end
endmodule
